/* inc/asp_pkg.sv */
// Shared constants and types of the async serial port.
// Assumes an 8-bit special-function-register bus on one clock.
package asp_pkg;
  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam logic [7:0] ASP_ADDR_CTRL  = 8'h98; // Control register
  localparam logic [7:0] ASP_ADDR_DATA  = 8'h99; // Data buffer
  localparam logic [7:0] ASP_CTRL_RESET = 8'h40; // Bit 6 reads one
  localparam logic [7:0] ASP_DATA_RESET = 8'h00; // Data buffer reset

  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int ASP_BIT_MODE  = 7; // Frame width select
  localparam int ASP_BIT_FIXED = 6; // Unimplemented, reads one
  localparam int ASP_BIT_MCE   = 5; // Multidrop filter enable
  localparam int ASP_BIT_REN   = 4; // Receive enable
  localparam int ASP_BIT_TB8   = 3; // Transmit ninth bit
  localparam int ASP_BIT_RB8   = 2; // Receive ninth bit
  localparam int ASP_BIT_TI    = 1; // Transmit done flag
  localparam int ASP_BIT_RI    = 0; // Receive done flag

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {ASP_TX_IDLE, ASP_TX_WAIT, ASP_TX_START,
                            ASP_TX_DATA, ASP_TX_NINTH, ASP_TX_STOP} asp_tx_state_t;
  typedef enum logic [2:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA,
                            ASP_RX_NINTH, ASP_RX_STOP} asp_rx_state_t;
endpackage

/* inc/asp_rx_if.sv */
// Link between the register logic and the receive sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface asp_rx_if;
  logic       enable;        // Reception permitted
  logic       nine_bit_mode; // Ninth bit present in frame
  logic       frame_done;    // One-cycle pulse at stop sample
  logic [7:0] data;          // Received byte
  logic       ninth;         // Received ninth bit
  logic       stop;          // Received stop bit level
  modport rcv (input enable, nine_bit_mode, output frame_done, data, ninth, stop);
  modport ctl (output enable, nine_bit_mode, input frame_done, data, ninth, stop);
endinterface
`default_nettype wire

/* design/asp_rx.sv */
// Receive sequencer of the async serial port.
// Assumes a synchronised line and a timer overflow pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module asp_rx
  import asp_pkg::*;
(
  input  wire logic mclk_in,     // System clock
  input  wire logic srst_in,     // Synchronous reset
  input  wire logic rx_line_in,  // Synchronised receive line
  input  wire logic baud_ovf_in, // Timer overflow pulse
  asp_rx_if.rcv     rx_bus       // Results to register logic
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    asp_rx_state_t state;     // Sequencer state
    logic          phase;     // Overflow halving phase
    logic [2:0]    cnt;       // Data bit count
    logic [7:0]    shift;     // Incoming byte, LSB first
    logic          ninth;     // Ninth bit sample
    logic          stop;      // Stop bit sample
    logic          done;      // Frame complete pulse
    logic          line_prev; // Line one cycle ago
  } asp_rx_reg_t;

  asp_rx_reg_t s;      // Current state
  asp_rx_reg_t next_s; // Next state
  logic        tick;   // Bit sample instant

  // Sample on every second overflow
  assign tick = baud_ovf_in && s.phase; // see RULE17

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.line_prev = rx_line_in;
    if (baud_ovf_in) begin
      next_s.phase = ~s.phase;
    end
    unique case (s.state)
      ASP_RX_IDLE: begin
        // Falling edge reloads bit timer, half a bit to centre
        if (rx_bus.enable && s.line_prev && !rx_line_in) begin // see RULE5
          next_s.state = ASP_RX_START;
          next_s.phase = 1'b1; // see RULE17
        end
      end
      ASP_RX_START: begin
        // Line high again at mid start bit: a glitch
        if (tick) begin
          next_s.state = rx_line_in ? ASP_RX_IDLE : ASP_RX_DATA; // see RULE18
          next_s.cnt = 3'h0;
        end
      end
      ASP_RX_DATA: begin
        // Eight data bits, least significant first
        if (tick) begin
          next_s.shift = {rx_line_in, s.shift[7:1]}; // see RULE15
          next_s.cnt = s.cnt + 3'h1;
          if (s.cnt == 3'h7) begin
            next_s.state = rx_bus.nine_bit_mode ? ASP_RX_NINTH : ASP_RX_STOP;
          end
        end
      end
      ASP_RX_NINTH: begin
        // Ninth bit before stop
        if (tick) begin
          next_s.ninth = rx_line_in;
          next_s.state = ASP_RX_STOP;
        end
      end
      ASP_RX_STOP: begin
        // Stop sample closes the frame
        if (tick) begin
          next_s.stop = rx_line_in;
          next_s.done = 1'b1; // see RULE10
          next_s.state = ASP_RX_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s <= '{state: ASP_RX_IDLE, phase: 1'b0, cnt: 3'h0, shift: 8'h00,
             ninth: 1'b0, stop: 1'b1, done: 1'b0, line_prev: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  // Results out
  assign rx_bus.frame_done = s.done;
  assign rx_bus.data = s.shift;
  assign rx_bus.ninth = s.ninth;
  assign rx_bus.stop = s.stop;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_recv_disabled: assert property (s.state == ASP_RX_IDLE && !rx_bus.enable |=> s.state == ASP_RX_IDLE) // see RULE5
    else $error("receiver left idle while disabled");
  a_false_start: assert property (s.state == ASP_RX_START && tick && rx_line_in |=> s.state == ASP_RX_IDLE) // see RULE18
    else $error("glitch start not rejected");
  c_frame_seen: cover property (s.done);
endmodule
`default_nettype wire

/* design/asp_top.sv */
// Control and data registers with transmit sequencer of the async serial port.
// Assumes an 8-bit register bus and a timer overflow pulse on mclk_in.
//
// What this block does
// RULE1 - Bit 7 selects 8-bit or 9-bit frames
// RULE2 - Control bit 6 reads one, ignores writes
// RULE3 - 8-bit filter accepts only high stop bit
// RULE4 - 9-bit filter accepts only ninth bit one
// RULE5 - Receive enable bit gates new frames
// RULE6 - Transmit ninth bit sent in 9-bit mode
// RULE7 - Receive ninth bit captures stop or ninth
// RULE8 - Transmit done set entering stop bit
// RULE9 - Done flags cleared only by software
// RULE10 - Receive done set at stop sample
// RULE11 - Set flag raises enabled interrupt request
// RULE12 - Data write loads and starts transmission
// RULE13 - Data read returns receive latch only
// RULE14 - Separate transmit and receive storage, one address
// RULE15 - Start, eight bits LSB first, stop
// RULE16 - Load only if receive done clear, filter passes
// RULE17 - Bit time is two overflows, start reloads
// RULE18 - Receive line synchronised before use
`timescale 1ns/1ps
`default_nettype none
module asp_top
  import asp_pkg::*;
(
  input  wire logic       mclk_in,       // System clock, 250 MHz
  input  wire logic       srst_in,       // Synchronous reset, active high
  input  wire logic [7:0] sfr_addr_in,   // Register address
  input  wire logic       sfr_wr_in,     // Write strobe
  input  wire logic       sfr_rd_in,     // Read strobe
  input  wire logic [7:0] sfr_wdata_in,  // Write data
  output logic      [7:0] sfr_rdata_out, // Read data, one cycle later
  input  wire logic       baud_ovf_in,   // Timer overflow pulse
  input  wire logic       int_enable_in, // Port interrupt enable
  input  wire logic       rx_pin_in,     // Receive pin
  output logic            tx_pin_out,    // Transmit pin
  output logic            irq_out        // Interrupt request
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic          rx_meta;  // Synchroniser first stage
    logic          rx_sync;  // Synchroniser second stage
    logic          mode;     // Frame width select
    logic          mce;      // Multidrop filter enable
    logic          ren;      // Receive enable
    logic          tb8;      // Transmit ninth bit
    logic          rb8;      // Receive ninth bit
    logic          ti;       // Transmit done flag
    logic          ri;       // Receive done flag
    logic [7:0]    rx_latch; // Receive latch
    logic [7:0]    tx_shift; // Transmit shift register
    asp_tx_state_t tx_state; // Transmit sequencer
    logic          tx_half;  // Overflow halving phase
    logic [2:0]    tx_cnt;   // Data bit count
    logic          tx_line;  // Transmit pin level
    logic [7:0]    rdata;    // Read data
  } asp_top_reg_t;

  asp_top_reg_t s;       // Current state
  asp_top_reg_t next_s;  // Next state
  asp_rx_if     rx_bus (); // Receiver link
  logic         tx_tick;   // Transmit bit boundary
  logic         wr_ctrl;   // Control write
  logic         wr_data;   // Data write
  logic         accept;    // Received frame passes filter

  // Control register as software sees it
  function automatic logic [7:0] asp_ctrl_view(input asp_top_reg_t r);
    logic [7:0] v;
    v = ASP_CTRL_RESET; // see RULE2
    v[ASP_BIT_MODE] = r.mode;
    v[ASP_BIT_MCE] = r.mce;
    v[ASP_BIT_REN] = r.ren;
    v[ASP_BIT_TB8] = r.tb8;
    v[ASP_BIT_RB8] = r.rb8;
    v[ASP_BIT_TI] = r.ti;
    v[ASP_BIT_RI] = r.ri;
    return v;
  endfunction

  // ****************************************
  // Receiver
  // ****************************************
  asp_rx u_rx (
    .mclk_in     (mclk_in),
    .srst_in     (srst_in),
    .rx_line_in  (s.rx_sync), // see RULE18
    .baud_ovf_in (baud_ovf_in),
    .rx_bus      (rx_bus.rcv)
  );
  assign rx_bus.enable = s.ren; // see RULE5
  assign rx_bus.nine_bit_mode = s.mode; // see RULE1

  // Decodes and frame filter
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == ASP_ADDR_CTRL);
  assign wr_data = sfr_wr_in && (sfr_addr_in == ASP_ADDR_DATA);
  assign tx_tick = baud_ovf_in && s.tx_half; // see RULE17
  // Stop bit checked in 8-bit mode, ninth bit in 9-bit mode
  assign accept = !s.ri && (!s.mce || (s.mode ? rx_bus.ninth : rx_bus.stop)); // see RULE3 see RULE4 see RULE16

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    // Two-stage pin synchroniser
    next_s.rx_meta = rx_pin_in;
    next_s.rx_sync = s.rx_meta;
    if (baud_ovf_in) begin
      next_s.tx_half = ~s.tx_half;
    end
    // Software writes; bit 6 is not stored
    if (wr_ctrl) begin
      next_s.mode = sfr_wdata_in[ASP_BIT_MODE];
      next_s.mce = sfr_wdata_in[ASP_BIT_MCE];
      next_s.ren = sfr_wdata_in[ASP_BIT_REN];
      next_s.tb8 = sfr_wdata_in[ASP_BIT_TB8];
      next_s.rb8 = sfr_wdata_in[ASP_BIT_RB8];
      next_s.ti = sfr_wdata_in[ASP_BIT_TI]; // see RULE9
      next_s.ri = sfr_wdata_in[ASP_BIT_RI]; // see RULE9
    end
    // Register reads; unmapped addresses read zero
    if (sfr_rd_in) begin
      if (sfr_addr_in == ASP_ADDR_CTRL) begin
        next_s.rdata = asp_ctrl_view(s);
      end else if (sfr_addr_in == ASP_ADDR_DATA) begin
        next_s.rdata = s.rx_latch; // see RULE13 see RULE14
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    // Accepted frame: hardware set wins over software clear
    if (rx_bus.frame_done && accept) begin
      next_s.rx_latch = rx_bus.data; // see RULE16
      next_s.rb8 = s.mode ? rx_bus.ninth : rx_bus.stop; // see RULE7
      next_s.ri = 1'b1; // see RULE10
    end
    // Transmit sequencer
    unique case (s.tx_state)
      ASP_TX_IDLE: begin
        // Write loads shift register and starts frame
        next_s.tx_line = 1'b1;
        if (wr_data) begin
          next_s.tx_shift = sfr_wdata_in; // see RULE12 see RULE14
          next_s.tx_state = ASP_TX_WAIT;
        end
      end
      ASP_TX_WAIT: begin
        // Align start bit to a bit boundary
        if (tx_tick) begin
          next_s.tx_line = 1'b0; // see RULE15
          next_s.tx_state = ASP_TX_START;
        end
      end
      ASP_TX_START: begin
        // First data bit after start
        if (tx_tick) begin
          next_s.tx_line = s.tx_shift[0];
          next_s.tx_cnt = 3'h0;
          next_s.tx_state = ASP_TX_DATA;
        end
      end
      ASP_TX_DATA: begin
        // Shift out LSB first
        if (tx_tick) begin
          next_s.tx_shift = {1'b0, s.tx_shift[7:1]};
          next_s.tx_cnt = s.tx_cnt + 3'h1;
          if (s.tx_cnt != 3'h7) begin
            next_s.tx_line = s.tx_shift[1]; // see RULE15
          end else if (s.mode) begin
            next_s.tx_line = s.tb8; // see RULE6
            next_s.tx_state = ASP_TX_NINTH;
          end else begin
            next_s.tx_line = 1'b1;
            next_s.ti = 1'b1; // see RULE8
            next_s.tx_state = ASP_TX_STOP;
          end
        end
      end
      ASP_TX_NINTH: begin
        // Stop bit begins, done flag set
        if (tx_tick) begin
          next_s.tx_line = 1'b1;
          next_s.ti = 1'b1; // see RULE8
          next_s.tx_state = ASP_TX_STOP;
        end
      end
      ASP_TX_STOP: begin
        // Stop bit lasts one bit time
        if (tx_tick) begin
          next_s.tx_state = ASP_TX_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s <= '{rx_meta: 1'b1, rx_sync: 1'b1, mode: 1'b0, mce: 1'b0, ren: 1'b0,
             tb8: 1'b0, rb8: 1'b0, ti: 1'b0, ri: 1'b0, rx_latch: ASP_DATA_RESET,
             tx_shift: ASP_DATA_RESET, tx_state: ASP_TX_IDLE, tx_half: 1'b0,
             tx_cnt: 3'h0, tx_line: 1'b1, rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sfr_rdata_out = s.rdata;
  assign tx_pin_out = s.tx_line;
  assign irq_out = int_enable_in && (s.ti || s.ri); // see RULE11

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_fixed_bit_one: assert property (sfr_rd_in && sfr_addr_in == ASP_ADDR_CTRL |=> sfr_rdata_out[6]) // see RULE2
    else $error("control bit 6 did not read one");
  a_data_read_latch: assert property (sfr_rd_in && sfr_addr_in == ASP_ADDR_DATA |=> sfr_rdata_out == $past(s.rx_latch)) // see RULE13
    else $error("data read did not return receive latch");
  a_flag_sticky: assert property (s.ri && s.ti && !wr_ctrl |=> s.ri && s.ti) // see RULE9
    else $error("done flag cleared without a write");
  a_irq_on_flag: assert property ($rose(s.ri) && int_enable_in |-> irq_out) // see RULE11
    else $error("no interrupt on receive done");
  a_ti_at_stop: assert property ($rose(s.ti) && !$past(wr_ctrl) |-> s.tx_state == ASP_TX_STOP && tx_pin_out) // see RULE8
    else $error("transmit done outside stop bit start");
  a_rx_accepted: assert property (rx_bus.frame_done && !s.ri && !s.mce
                                  |=> s.ri && s.rx_latch == $past(rx_bus.data)) // see RULE10
    else $error("accepted frame not latched");
  a_filter_drop: assert property (rx_bus.frame_done && s.mce && !(s.mode ? rx_bus.ninth : rx_bus.stop) && !wr_ctrl
                                  |=> s.ri == $past(s.ri) && $stable(s.rx_latch)) // see RULE3
    else $error("filtered frame was loaded");
  a_ninth_sent: assert property (s.tx_state == ASP_TX_DATA && tx_tick && s.tx_cnt == 3'h7 && s.mode
                                 |=> tx_pin_out == $past(s.tb8)) // see RULE6
    else $error("ninth bit level wrong");
  c_rx_accept: cover property (rx_bus.frame_done && accept);
  c_tx_nine: cover property (s.tx_state == ASP_TX_NINTH);
  c_tx_done: cover property ($rose(s.ti));
endmodule
`default_nettype wire

/* verif/asp_remote_model.sv */
// Remote serial node facing the async serial port: sends and captures frames.
// Assumes the bench clock and a bit time of BIT_CYC system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module asp_remote_model #(
  parameter int BIT_CYC = 8  // Cycles per bit, two overflow periods
) (
  input  wire logic mclk_in,  // System clock
  input  wire logic line_in,  // Port transmit pin
  output logic      line_out  // Port receive pin, idles high
);
  // ********************************
  // Frame sender
  // ********************************
  initial line_out = 1'b1;  // Idle high from time zero

  // Start, data LSB first, ninth in 9-bit frames, stop
  task automatic send(input logic nine, input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] f;
    f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      line_out = f[i];
      repeat (BIT_CYC) @(negedge mclk_in);
    end
    line_out = 1'b1;
    repeat (2 * BIT_CYC) @(negedge mclk_in);
  endtask

  // ********************************
  // Frame capture
  // ********************************
  // Waits for a start edge, then samples each bit at its middle
  task automatic grab(input logic nine, output logic [7:0] d, output logic b9,
                      output logic stp, output logic tmo);
    int n;
    n = 0;
    b9 = 1'b0;
    while (line_in !== 1'b0 && n < 4000) begin
      @(negedge mclk_in);
      n++;
    end
    tmo = (n >= 4000);
    repeat (BIT_CYC / 2) @(negedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge mclk_in);
      d[i] = line_in;
    end
    if (nine) begin
      repeat (BIT_CYC) @(negedge mclk_in);
      b9 = line_in;
    end
    repeat (BIT_CYC) @(negedge mclk_in);
    stp = line_in;
  endtask
endmodule
`default_nettype wire

/* verif/async_serial_ctrl_data_regs_tb_top.sv */
// Self-checking bench of the async serial port registers and frames.
// Assumes asp_top, asp_pkg and the remote node model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_data_regs_tb_top import asp_pkg::*;;
  // ********************************
  // Signals and bookkeeping
  // ********************************
  typedef struct packed {
    logic       mode;  // 9-bit frames
    logic       mce;   // Multidrop filter
    logic       tb8;   // Transmit ninth bit
    logic [7:0] data;  // Byte received; its inverse is transmitted
    logic       b9;    // Received ninth bit
    logic       stp;   // Received stop bit
    logic       acc;   // Frame should be taken
  } asp_row_t;
  asp_row_t   rows [6] = '{
    '{1'b0, 1'b0, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b1},
    '{1'b0, 1'b1, 1'b0, 8'h3C, 1'b0, 1'b0, 1'b0},
    '{1'b0, 1'b1, 1'b0, 8'hC3, 1'b0, 1'b1, 1'b1},
    '{1'b1, 1'b0, 1'b1, 8'h96, 1'b0, 1'b1, 1'b1},
    '{1'b1, 1'b1, 1'b1, 8'h0F, 1'b0, 1'b1, 1'b0},
    '{1'b1, 1'b1, 1'b0, 8'hF0, 1'b1, 1'b1, 1'b1}};
  asp_row_t   r;              // Current row
  logic       mclk_in;        // System clock
  logic       srst_in;        // Synchronous reset
  logic [7:0] sfr_addr_in;    // Register address
  logic       sfr_wr_in;      // Write strobe
  logic       sfr_rd_in;      // Read strobe
  logic [7:0] sfr_wdata_in;   // Write data
  logic [7:0] sfr_rdata_out;  // Read data
  logic       baud_ovf_in;    // Timer overflow pulse
  logic       int_enable_in;  // Interrupt enable
  logic       rx_pin_in;      // Line from remote node
  logic       tx_pin_out;     // Line to remote node
  logic       irq_out;        // Interrupt request
  logic [1:0] ovf_cnt;        // Overflow divider
  logic [7:0] last;           // Last accepted byte
  logic [7:0] exp_ctrl;       // Expected control view
  int         failures;       // Mismatch count
  int         compares;       // Comparison count

  asp_top uut (
    .mclk_in       (mclk_in),
    .srst_in       (srst_in),
    .sfr_addr_in   (sfr_addr_in),
    .sfr_wr_in     (sfr_wr_in),
    .sfr_rd_in     (sfr_rd_in),
    .sfr_wdata_in  (sfr_wdata_in),
    .sfr_rdata_out (sfr_rdata_out),
    .baud_ovf_in   (baud_ovf_in),
    .int_enable_in (int_enable_in),
    .rx_pin_in     (rx_pin_in),
    .tx_pin_out    (tx_pin_out),
    .irq_out       (irq_out)
  );
  asp_remote_model #(.BIT_CYC(8)) model (.mclk_in(mclk_in), .line_in(tx_pin_out), .line_out(rx_pin_in));

  // ********************************
  // Clock, overflow pulse, watchdog
  // ********************************
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // One overflow every 4 cycles, so a bit lasts 8 cycles
  always @(negedge mclk_in) begin
    ovf_cnt <= ovf_cnt + 2'h1;
    baud_ovf_in <= (ovf_cnt == 2'h3);
  end
  initial begin
    repeat (100000) @(posedge mclk_in);
    failures++;
    give_verdict();
  end

  // ********************************
  // Bus and check tasks
  // ********************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    @(negedge mclk_in);
    sfr_wr_in = 1'b0;
  endtask
  // Read data is taken one cycle after the read edge
  task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge mclk_in);
    sfr_rd_in = 1'b0;
    check(what, exp, sfr_rdata_out);
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Writes a byte, optionally a second one while busy, captures the frame
  task automatic tx_check(input logic nine, input logic [7:0] d, input logic b9, input logic dup);
    logic [7:0] gd;
    logic       gb;
    logic       gs;
    logic       tmo;
    fork
      model.grab(nine, gd, gb, gs, tmo);
      begin
        wr(ASP_ADDR_DATA, d);
        if (dup) wr(ASP_ADDR_DATA, ~d);
      end
    join
    if (tmo) begin
      failures++;
      give_verdict();
    end else begin
      check("tx data", d, gd);
      check("tx ninth", {7'h00, b9}, {7'h00, gb});
      check("tx stop", 8'h01, {7'h00, gs});
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    srst_in = 1'b1;
    sfr_addr_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    sfr_wdata_in = 8'h00;
    int_enable_in = 1'b0;
    baud_ovf_in = 1'b0;
    ovf_cnt = 2'h0;
    failures = 0;
    compares = 0;
    last = ASP_DATA_RESET;
    repeat (4) @(negedge mclk_in);
    srst_in = 1'b0;
    // Reset view, fixed bit, unmapped place
    check("tx idle", 8'h01, {7'h00, tx_pin_out});
    rd_check("ctrl reset", ASP_ADDR_CTRL, ASP_CTRL_RESET);
    rd_check("data reset", ASP_ADDR_DATA, ASP_DATA_RESET);
    rd_check("unmapped", 8'h9A, 8'h00);
    wr(ASP_ADDR_CTRL, 8'h00);
    model.send(1'b0, 8'h5A, 1'b0, 1'b1);
    rd_check("receive off", ASP_ADDR_CTRL, 8'h40);
    $display("test reset and receive off done");
    // Table of frames in both directions
    int_enable_in = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wr(ASP_ADDR_CTRL, {r.mode, 1'b0, r.mce, 1'b1, r.tb8, 3'h0});
      tx_check(r.mode, r.data ^ 8'hFF, r.mode & r.tb8, 1'b0);
      model.send(r.mode, r.data, r.b9, r.stp);
      exp_ctrl = {r.mode, 1'b1, r.mce, 1'b1, r.tb8, r.acc & (r.mode ? r.b9 : r.stp), 1'b1, r.acc};
      rd_check("ctrl after frames", ASP_ADDR_CTRL, exp_ctrl);
      check("irq set", 8'h01, {7'h00, irq_out});
      if (r.acc) last = r.data;
      rd_check("rx data", ASP_ADDR_DATA, last);
      wr(ASP_ADDR_CTRL, 8'h00);
      check("irq cleared", 8'h00, {7'h00, irq_out});
      $display("test row %0d done", i);
    end
    // Receive done alone raises the request, transmit done clear
    wr(ASP_ADDR_CTRL, 8'h10);
    model.send(1'b0, 8'h3B, 1'b0, 1'b1);
    check("irq on rx", 8'h01, {7'h00, irq_out});
    last = 8'h3B;
    rd_check("rx only data", ASP_ADDR_DATA, last);
    $display("test receive interrupt done");
    // Overrun with receive done already set, interrupt masked
    int_enable_in = 1'b0;
    wr(ASP_ADDR_CTRL, 8'h11);
    model.send(1'b0, 8'h77, 1'b0, 1'b1);
    rd_check("overrun ctrl", ASP_ADDR_CTRL, 8'h51);
    rd_check("overrun data", ASP_ADDR_DATA, last);
    check("irq masked", 8'h00, {7'h00, irq_out});
    int_enable_in = 1'b1;
    @(negedge mclk_in);
    check("irq unmasked", 8'h01, {7'h00, irq_out});
    wr(ASP_ADDR_CTRL, 8'h00);
    $display("test overrun done");
    // Second write while busy must not disturb the frame
    tx_check(1'b0, 8'h55, 1'b0, 1'b1);
    $display("test busy write done");
    // Reset in mid-run clears settings and flags
    wr(ASP_ADDR_CTRL, 8'hFF);
    srst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    srst_in = 1'b0;
    check("irq after reset", 8'h00, {7'h00, irq_out});
    check("tx after reset", 8'h01, {7'h00, tx_pin_out});
    rd_check("ctrl after reset", ASP_ADDR_CTRL, ASP_CTRL_RESET);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
